// [src/stepper_pkg.sv]
// Function
// - System reset combines power-on reset and the active-low reset pin.
// - Power-on reset holds logic initialised until supply reaches 4V.
// - Enable low forces all four phase drive outputs off.
// - Enable low freezes internal state; only reset still acts. Here the step edge tracker still follows the pin and APB writes still act.
// - Enable high again resumes from the held excitation step.
// - Open-drain fault flag pulls low while any detector has tripped.
// - Fault kind encodes open, overcurrent or overheat as three levels.
// - A trip latches and keeps phase outputs off until reset.
// - Latched faults clear only by reset pin or power-on reset.
// - Missing flyback current in a PWM off period trips open detection.
// - PWM blanks detection 5.5us, a quarter period; not initial rise.
package stepper_pkg;

    localparam int CLK_MHZ = 20;
    localparam int BLANK_NS = 5500;
    localparam int BLANK_CYCLES = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int PERIOD_PER_BLANK = 4;
    localparam int CNT_W = 9;

    // APB map
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam int CTRL_OPEN_EN_BIT = 0;
    localparam logic CTRL_OPEN_EN_RST = 1'b1;

    // Latched fault vector
    localparam int F_OPEN = 0;
    localparam int F_OC = 1;
    localparam int F_OH = 2;

    // Fault kind codes, mapped to divider taps outside
    localparam logic [1:0] FK_NONE = 2'h0;
    localparam logic [1:0] FK_OPEN = 2'h1;
    localparam logic [1:0] FK_OC = 2'h2;
    localparam logic [1:0] FK_OH = 2'h3;

    typedef enum logic [1:0] {
        CH_RISE = 2'b00,
        CH_ON = 2'b01,
        CH_OFF = 2'b10
    } chop_state_t;

    typedef struct packed {
        logic a;
        logic a_ret;
        logic b;
        logic b_ret;
    } phase_drive_t;

    localparam phase_drive_t DRIVE_OFF = '0;

endpackage

// [src/input_sync.sv]
module input_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pins and filtered levels
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    if (WIDTH < 1) begin : g_chk
        $error("input_sync: WIDTH must be positive");
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Accept a change only once two stages agree
    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                level_out[i] <= 1'b0;
            end else if (s2_reg[i] == s3_reg[i]) begin
                level_out[i] <= s3_reg[i];
            end
        end
    end

endmodule

// [src/stepper_driver_protect_ctrl.sv]
// Register access over APB and the placing of the registers were decided locally.
module stepper_driver_protect_ctrl
    import stepper_pkg::*;
#(
    parameter int BLANK_CYC = BLANK_CYCLES,
    parameter int PERIOD_CYC = BLANK_CYCLES * PERIOD_PER_BLANK
) (
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Controller pins
    input wire logic system_reset_low,
    input wire logic enable_in,
    input wire logic step_clk,
    input wire logic dir_ccw,
    // Analog detector levels
    input wire logic over_setpoint,
    input wire logic overcurrent_det,
    input wire logic overheat_det,
    input wire logic flyback_det,
    // Phase drive
    output phase_drive_t phase_drive,
    // Fault reporting
    output logic fault_flag_low_out,
    output logic fault_flag_low_oe,
    output logic [1:0] fault_kind_level
);

    localparam logic [CNT_W-1:0] BLANK_LAST = CNT_W'(BLANK_CYC - 1);
    localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYC - 1);
    localparam logic [CNT_W-1:0] BLANK_END = CNT_W'(BLANK_CYC);

    if (BLANK_CYC < 1 || PERIOD_CYC <= BLANK_CYC ||
        PERIOD_CYC > (1 << CNT_W)) begin : g_chk
        $error("stepper_driver_protect_ctrl: bad PWM timing");
    end

    logic [7:0] pins_q;
    logic rst_pin_q;
    logic en_q;
    logic step_q;
    logic dir_q;
    logic overset_q;
    logic oc_q;
    logic oh_q;
    logic fly_q;

    input_sync #(.WIDTH(8)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_in({system_reset_low, enable_in, step_clk, dir_ccw,
                 over_setpoint, overcurrent_det, overheat_det, flyback_det}),
        .level_out(pins_q)
    );

    assign {rst_pin_q, en_q, step_q, dir_q, overset_q, oc_q, oh_q, fly_q} =
        pins_q;

    logic sys_rst;
    logic run;
    logic step_prev_reg;
    logic step_edge;
    logic [1:0] step_idx_reg;
    chop_state_t chop_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic fly_seen_reg;
    logic [2:0] fault_reg;
    logic [2:0] trip;
    logic blank;
    logic off_end;
    logic open_en_reg;
    logic [1:0] kind_reg;

    // POR via rstn, pin reset synchronously; pin reset is held after POR
    assign sys_rst = ~rst_pin_q;
    assign run = en_q & ~sys_rst;
    assign step_edge = step_q & ~step_prev_reg;
    assign blank = (chop_reg == CH_ON) &&
                   (cnt_reg <= BLANK_LAST);
    assign off_end = (chop_reg == CH_OFF) && (cnt_reg == PERIOD_LAST);

    function automatic phase_drive_t step_pattern(input logic [1:0] idx);
        phase_drive_t p;
        p = DRIVE_OFF;
        p.a = ~idx[1] ^ idx[0];
        p.a_ret = ~p.a;
        p.b = ~idx[1];
        p.b_ret = idx[1];
        return p;
    endfunction

    // Edge tracker follows the pin even when frozen, so idle edges are lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step_prev_reg <= 1'b0;
        end else begin
            step_prev_reg <= step_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step_idx_reg <= 2'h0;
        end else if (sys_rst) begin
            step_idx_reg <= 2'h0;
        end else if (run && step_edge) begin
            step_idx_reg <= dir_q ? step_idx_reg - 2'h1 : step_idx_reg + 2'h1;
        end
    end // Held while disabled

    // Chopper: initial rise unblanked, then fixed period with blanking
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chop_reg <= CH_RISE;
            cnt_reg <= '0;
        end else if (sys_rst || (run && step_edge)) begin
            chop_reg <= CH_RISE;
            cnt_reg <= '0;
        end else if (run) begin
            case (chop_reg)
                CH_RISE: begin
                    if (overset_q) begin
                        chop_reg <= CH_OFF;
                        cnt_reg <= BLANK_END;
                    end
                end
                CH_ON: begin
                    if (cnt_reg == PERIOD_LAST) begin
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                        if (!blank && overset_q) begin
                            chop_reg <= CH_OFF;
                        end
                    end
                end
                CH_OFF: begin
                    if (off_end) begin
                        chop_reg <= CH_ON;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                end
                default: begin
                    chop_reg <= CH_RISE;
                    cnt_reg <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fly_seen_reg <= 1'b0;
        end else if (sys_rst || chop_reg != CH_OFF) begin
            fly_seen_reg <= 1'b0;
        end else if (run && fly_q) begin
            fly_seen_reg <= 1'b1;
        end
    end

    always_comb begin
        trip = '0;
        if (run) begin
            trip[F_OPEN] = open_en_reg && off_end &&
                           !fly_seen_reg && !fly_q;
            trip[F_OC] = oc_q && !blank;
            trip[F_OH] = oh_q;
        end
    end

    // Latched faults; only system reset clears them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_reg <= '0;
        end else if (sys_rst) begin
            fault_reg <= '0;
        end else begin
            fault_reg <= fault_reg | trip;
        end
    end

    // First trip names the kind; overheat wins a tie
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            kind_reg <= FK_NONE;
        end else if (sys_rst) begin
            kind_reg <= FK_NONE;
        end else if (fault_reg == '0) begin
            if (trip[F_OH]) begin
                kind_reg <= FK_OH;
            end else if (trip[F_OC]) begin
                kind_reg <= FK_OC;
            end else if (trip[F_OPEN]) begin
                kind_reg <= FK_OPEN;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_drive <= DRIVE_OFF;
            fault_flag_low_oe <= 1'b0;
            fault_flag_low_out <= 1'b0;
            fault_kind_level <= FK_NONE;
        end else begin
            if (run && fault_reg == '0 && trip == '0 &&
                chop_reg != CH_OFF) begin
                phase_drive <= step_pattern(step_idx_reg);
            end else begin
                phase_drive <= DRIVE_OFF;
            end
            fault_flag_low_oe <= |fault_reg;
            fault_flag_low_out <= 1'b0;
            fault_kind_level <= kind_reg;
        end
    end

    // APB: one wait-free access phase, pready raised from the setup cycle
    logic hit;
    assign hit = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    CTRL_ADDR: prdata <= {31'h0, open_en_reg};
                    STATUS_ADDR: prdata <= {16'h0, 2'h0, chop_reg, 2'h0,
                                            step_idx_reg, 1'b0, en_q,
                                            kind_reg, 1'b0, fault_reg};
                    default: prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            open_en_reg <= CTRL_OPEN_EN_RST;
        end else if (psel && penable && pready && pwrite &&
                     paddr == CTRL_ADDR) begin
            open_en_reg <= pwdata[CTRL_OPEN_EN_BIT];
        end
    end

    reset_step_a: assert property (
        @(posedge clk) disable iff (!rstn)
        sys_rst |=> step_idx_reg == 2'h0 && chop_reg == CH_RISE)
        else $error("pin reset did not initialise step");

    enable_off_a: assert property (
        @(posedge clk) disable iff (!rstn)
        !en_q |=> phase_drive == DRIVE_OFF)
        else $error("phase drive on while disabled");

    frozen_state_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (!en_q && !sys_rst) |=> $stable(step_idx_reg) && $stable(cnt_reg)
        && $stable(fault_reg))
        else $error("state moved while disabled");

    // One cycle back: a step taken just before the disable is legal
    resume_step_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (!en_q && !sys_rst) ##1 (en_q && !sys_rst)
        |-> step_idx_reg == $past(step_idx_reg))
        else $error("step lost across disable");

    fault_flag_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ##1 fault_flag_low_oe == $past(|fault_reg))
        else $error("fault flag disagrees with latched faults");

    fault_kind_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (fault_reg == '0 && trip == 3'b001 && !sys_rst)
        |=> ##1 fault_kind_level == FK_OPEN)
        else $error("open fault kind wrong");

    latch_off_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (fault_reg != '0 && !sys_rst) |=> fault_reg != '0
        && phase_drive == DRIVE_OFF)
        else $error("fault not held or drive not off");

    fault_clear_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (fault_reg != '0) ##1 (fault_reg == '0) |-> $past(sys_rst))
        else $error("fault cleared without reset");

    open_trip_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (run && open_en_reg && off_end && !fly_seen_reg && !fly_q)
        |=> fault_reg[F_OPEN])
        else $error("open terminal not latched");

    blank_oc_a: assert property (
        @(posedge clk) disable iff (!rstn)
        (run && blank && !fault_reg[F_OC]) |=> !fault_reg[F_OC])
        else $error("overcurrent taken inside blanking");

endmodule

// [sim/stepper_ctrl_model.sv]
module stepper_ctrl_model (
    // Clock
    input wire logic clk,
    // Controller pins
    output logic system_reset_low,
    output logic enable_in,
    output logic step_clk,
    output logic dir_ccw
);
    timeunit 1ns;
    timeprecision 1ps;

    // 10 us and 30 us at 50 ns per cycle
    localparam int RESET_WAIT = 200;
    localparam int ENABLE_QUIET = 600;

    initial begin
        system_reset_low = 1'b0;
        enable_in = 1'b0;
        step_clk = 1'b0;
        dir_ccw = 1'b0;
    end

    task automatic pulse_reset();
        @(posedge clk);
        system_reset_low <= 1'b1;
        repeat (4) @(posedge clk);
        system_reset_low <= 1'b0;
        repeat (8) @(posedge clk);
        system_reset_low <= 1'b1;
        repeat (RESET_WAIT) @(posedge clk);
    endtask

    // Rising enable is followed by a quiet time without chopping
    task automatic set_enable(input logic v);
        @(posedge clk);
        enable_in <= v;
        if (v) begin
            repeat (ENABLE_QUIET) @(posedge clk);
        end
    endtask

    // Direction settles well before the first edge
    task automatic step(input int n, input logic ccw);
        int gap;
        gap = 12;
        @(posedge clk);
        dir_ccw <= ccw;
        repeat (12) @(posedge clk);
        for (int k = 0; k < n; k++) begin
            step_clk <= 1'b1;
            repeat (12) @(posedge clk);
            step_clk <= 1'b0;
            repeat (gap) @(posedge clk);
            gap = gap + 4;
        end
    endtask
endmodule

// [sim/stepper_driver_protect_ctrl_tb_top.sv]
module stepper_driver_protect_ctrl_tb_top
    import stepper_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic system_reset_low;
    logic enable_in;
    logic step_clk;
    logic dir_ccw;
    logic over_setpoint;
    logic overcurrent_det;
    logic overheat_det;
    logic flyback_det;
    phase_drive_t phase_drive;
    logic fault_flag_low_out;
    logic fault_flag_low_oe;
    logic [1:0] fault_kind_level;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [1:0] idx = 2'h0;
    // Open-drain flag with its pull-up
    wire fault_pin = fault_flag_low_oe ? fault_flag_low_out : 1'b1;

    stepper_driver_protect_ctrl #(.BLANK_CYC(4), .PERIOD_CYC(16)) dut_u (
        .clk(clk),
        .rstn(rstn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .system_reset_low(system_reset_low),
        .enable_in(enable_in),
        .step_clk(step_clk),
        .dir_ccw(dir_ccw),
        .over_setpoint(over_setpoint),
        .overcurrent_det(overcurrent_det),
        .overheat_det(overheat_det),
        .flyback_det(flyback_det),
        .phase_drive(phase_drive),
        .fault_flag_low_out(fault_flag_low_out),
        .fault_flag_low_oe(fault_flag_low_oe),
        .fault_kind_level(fault_kind_level)
    );

    stepper_ctrl_model ctrl_u (
        .clk(clk),
        .system_reset_low(system_reset_low),
        .enable_in(enable_in),
        .step_clk(step_clk),
        .dir_ccw(dir_ccw)
    );

    always #25 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic phase_drive_t pat(input logic [1:0] i);
        pat.a = ~i[1] ^ i[0];
        pat.a_ret = ~pat.a;
        pat.b = ~i[1];
        pat.b_ret = i[1];
    endfunction

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Pin inputs pass a synchroniser, so allow a bounded settle
    task automatic chk_drive(input phase_drive_t exp);
        for (int k = 0; k < 20 && phase_drive !== exp; k++) @(posedge clk);
        chk32({28'h0, phase_drive}, {28'h0, exp});
    endtask

    task automatic chk_fault(input logic pin, input logic [1:0] kind);
        for (int k = 0; k < 60 && {fault_pin, fault_kind_level} !== {pin, kind};
             k++) @(posedge clk);
        chk32({29'h0, fault_pin, fault_kind_level}, {29'h0, pin, kind});
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset_values();
        logic [31:0] r;
        logic e;
        chk_drive(DRIVE_OFF);
        chk_fault(1'b1, FK_NONE);
        apb(CTRL_ADDR, 1'b0, 32'h0, r, e);
        chk32(r, {31'h0, CTRL_OPEN_EN_RST});
        apb(12'h008, 1'b0, 32'h0, r, e);
        chk32(r, 32'h0);
        chk32({31'h0, e}, 32'h1);
    endtask

    task automatic t_steps_enable();
        ctrl_u.pulse_reset();
        ctrl_u.set_enable(1'b1);
        chk_drive(pat(idx));
        ctrl_u.step(1, 1'b0);
        idx = idx + 2'h1;
        chk_drive(pat(idx));
        // Leave a non-reset step so a reinitialised sequence shows
        ctrl_u.step(2, 1'b0);
        idx = idx + 2'h2;
        chk_drive(pat(idx));
        ctrl_u.set_enable(1'b0);
        chk_drive(DRIVE_OFF);
        overheat_det <= 1'b1;
        ctrl_u.step(2, 1'b1);
        overheat_det <= 1'b0;
        repeat (10) @(posedge clk);
        ctrl_u.set_enable(1'b1);
        chk_drive(pat(idx));
        chk_fault(1'b1, FK_NONE);
    endtask

    task automatic t_trip(input int which, input logic [1:0] kind,
                          input logic por);
        logic [31:0] r;
        logic e;
        logic [31:0] want;
        want = {26'h0, kind, 4'h0} | (32'h1 << which);
        if (which == F_OC) begin
            overcurrent_det <= 1'b1;
        end else begin
            overheat_det <= 1'b1;
        end
        chk_fault(1'b0, kind);
        chk_drive(DRIVE_OFF);
        overcurrent_det <= 1'b0;
        overheat_det <= 1'b0;
        // Low long enough to pass the input filter
        ctrl_u.set_enable(1'b0);
        repeat (10) @(posedge clk);
        ctrl_u.set_enable(1'b1);
        chk_fault(1'b0, kind);
        chk_drive(DRIVE_OFF);
        apb(STATUS_ADDR, 1'b0, 32'h0, r, e);
        chk32(r & 32'h37, want);
        if (por) begin
            rstn <= 1'b0;
            repeat (2) @(posedge clk);
            rstn <= 1'b1;
        end else begin
            ctrl_u.pulse_reset();
        end
        chk_fault(1'b1, FK_NONE);
        idx = 2'h0;
        chk_drive(pat(idx));
    endtask

    // One chop: current over the setting, then a whole off period
    task automatic chop(input logic fly);
        flyback_det <= fly;
        over_setpoint <= 1'b1;
        repeat (10) @(posedge clk);
        over_setpoint <= 1'b0;
        repeat (60) @(posedge clk);
    endtask

    task automatic t_open();
        logic [31:0] r;
        logic e;
        apb(CTRL_ADDR, 1'b1, 32'h0, r, e);
        chop(1'b0);
        chk_fault(1'b1, FK_NONE);
        apb(CTRL_ADDR, 1'b1, 32'h1, r, e);
        chop(1'b1);
        chk_fault(1'b1, FK_NONE);
        chop(1'b0);
        chk_fault(1'b0, FK_OPEN);
        chk_drive(DRIVE_OFF);
        ctrl_u.pulse_reset();
        chk_fault(1'b1, FK_NONE);
    endtask

    initial begin
        paddr <= 12'h000;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        pwdata <= 32'h0;
        over_setpoint <= 1'b0;
        overcurrent_det <= 1'b0;
        overheat_det <= 1'b0;
        flyback_det <= 1'b1;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_reset_values();
        t_steps_enable();
        t_trip(F_OH, FK_OH, 1'b0);
        t_trip(F_OC, FK_OC, 1'b1);
        t_open();
        report_and_stop();
    end
endmodule
